// ### include/popc_pkg.sv
// Register map and constants for the port output and pad control block
package popc_pkg;

    // Bus widths
    localparam int POPC_ADDR_W = 18;
    localparam int POPC_DATA_W = 32;

    // Register indices; the byte address is four times the index
    localparam logic [15:0] POPC_IDX_PORT_D_OUT = 16'hFF6C;
    localparam logic [15:0] POPC_IDX_PORT_E_OUT = 16'hFF6D;
    localparam logic [15:0] POPC_IDX_PORT_F_OUT = 16'hFF6E;
    localparam logic [15:0] POPC_IDX_PORT_G_OUT = 16'hFF6F;
    localparam logic [15:0] POPC_IDX_PORT_A_PU  = 16'hFF70;
    localparam logic [15:0] POPC_IDX_PORT_B_PU  = 16'hFF71;
    localparam logic [15:0] POPC_IDX_PORT_C_PU  = 16'hFF72;
    localparam logic [15:0] POPC_IDX_PORT_D_PU  = 16'hFF73;
    localparam logic [15:0] POPC_IDX_PORT_E_PU  = 16'hFF74;
    localparam logic [15:0] POPC_IDX_PORT_3_OD  = 16'hFF76;
    localparam logic [15:0] POPC_IDX_PORT_A_OD  = 16'hFF77;

    // Slot array spans the first to the last index
    localparam logic [15:0] POPC_IDX_BASE = POPC_IDX_PORT_D_OUT;
    localparam int          POPC_NSLOT    = 12;

    // Slot numbers, index minus base
    localparam int POPC_SLOT_D_OUT = int'(POPC_IDX_PORT_D_OUT - POPC_IDX_BASE);
    localparam int POPC_SLOT_E_OUT = int'(POPC_IDX_PORT_E_OUT - POPC_IDX_BASE);
    localparam int POPC_SLOT_F_OUT = int'(POPC_IDX_PORT_F_OUT - POPC_IDX_BASE);
    localparam int POPC_SLOT_G_OUT = int'(POPC_IDX_PORT_G_OUT - POPC_IDX_BASE);
    localparam int POPC_SLOT_A_PU  = int'(POPC_IDX_PORT_A_PU - POPC_IDX_BASE);
    localparam int POPC_SLOT_B_PU  = int'(POPC_IDX_PORT_B_PU - POPC_IDX_BASE);
    localparam int POPC_SLOT_C_PU  = int'(POPC_IDX_PORT_C_PU - POPC_IDX_BASE);
    localparam int POPC_SLOT_D_PU  = int'(POPC_IDX_PORT_D_PU - POPC_IDX_BASE);
    localparam int POPC_SLOT_E_PU  = int'(POPC_IDX_PORT_E_PU - POPC_IDX_BASE);
    localparam int POPC_SLOT_3_OD  = int'(POPC_IDX_PORT_3_OD - POPC_IDX_BASE);
    localparam int POPC_SLOT_A_OD  = int'(POPC_IDX_PORT_A_OD - POPC_IDX_BASE);

    // Writable bits of each slot, highest slot first
    localparam logic [11:0][7:0] POPC_WMASK = {
        8'hFF, 8'h3F, 8'h00, 8'hFF, 8'hFF, 8'hFF,
        8'hFF, 8'hFF, 8'h1F, 8'hFF, 8'hFF, 8'hFF};

    // Slots that exist; the slot between pull-ups and open-drain is a hole
    localparam logic [11:0] POPC_SLOT_PRESENT  = 12'hDFF;
    // Slots that exist only with on-chip program memory
    localparam logic [11:0] POPC_SLOT_ROM_ONLY = 12'h9F0;

    // Value of every register after reset
    localparam logic [7:0] POPC_RST_VAL = 8'h00;

    // Bus responses
    localparam logic [1:0] POPC_RESP_OKAY   = 2'h0;
    localparam logic [1:0] POPC_RESP_DECERR = 2'h3;

endpackage : popc_pkg

// ### verilog/popc_reg.sv
// One byte-wide control register with a fixed write mask
`timescale 1ns/1ps
module popc_reg
    import popc_pkg::*;
#(
    parameter logic [7:0] MASK = 8'hFF
)
(
    // Clock and reset
    input  wire logic       aclk,
    input  wire logic       aresetn,
    // Write strobe and byte
    input  wire logic       wr_en,
    input  wire logic [7:0] wr_byte,
    // Stored value, unimplemented bits zero
    output logic      [7:0] rd_byte
);
    typedef struct packed {
        logic [7:0] val;
    } popc_reg_t;

    popc_reg_t q;
    popc_reg_t d;

    // Masking on write keeps unimplemented bits at zero for ever
    always_comb
    begin
        d = q;
        if (wr_en)
        begin
            d.val = wr_byte & MASK;
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            q <= '{val: POPC_RST_VAL};
        else
            q <= d;
    end

    assign rd_byte = q.val;

endmodule : popc_reg

// ### verilog/popc_pad.sv
// Per-pin pad drive and pull-up control for one port
`timescale 1ns/1ps
module popc_pad
#(
    parameter int W = 8
)
(
    // Clock and reset
    input  wire logic         aclk,
    input  wire logic         aresetn,
    // Pin direction (1 = output) and data being driven
    input  wire logic [W-1:0] dir,
    input  wire logic [W-1:0] data,
    // Open-drain select and pull-up enable
    input  wire logic [W-1:0] od,
    input  wire logic [W-1:0] pue,
    // Pad controls
    output logic      [W-1:0] oe,
    output logic      [W-1:0] pull
);
    typedef struct packed {
        logic [W-1:0] oe;
        logic [W-1:0] pull;
    } popc_pad_t;

    popc_pad_t q;
    popc_pad_t d;

    // Open-drain pins drop drive for a high; pull-up only on inputs
    always_comb
    begin
        d.oe   = dir & ~(od & data);
        // R10: pull on inputs
        d.pull = pue & ~dir;
    end

    // Registered so pad controls never glitch on a decode change
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            q <= '0;
        else
            q <= d;
    end

    assign oe   = q.oe;
    assign pull = q.pull;

endmodule : popc_pad

// ### verilog/popc_top.sv
// Port output latches and pad control registers on an AXI4-Lite slave
`timescale 1ns/1ps
// Operation
// R1: Port D output latch, eight bits
// R2: Port E output latch, eight bits
// R3: Port F output latch, eight bits
// R4: Port G latch, five pins four..zero
// R5: Per-pin pull-up enables, ports A to E
// R6: Port 3 open-drain, low six bits
// R7: Port A open-drain, all eight bits
// R8: Pull-up and port A open-drain need ROM
// R9: Everything clears to zero on reset
// R10: Pull-up active only on input pins
module popc_top
    import popc_pkg::*;
#(
    parameter bit ONCHIP_ROM = 1'b1
)
(
    // Clock and reset
    input  wire logic                   aclk,
    input  wire logic                   aresetn,
    // AXI4-Lite write address and data
    input  wire logic                   awvalid,
    output logic                        awready,
    input  wire logic [POPC_ADDR_W-1:0] awaddr,
    input  wire logic                   wvalid,
    output logic                        wready,
    input  wire logic [POPC_DATA_W-1:0] wdata,
    input  wire logic [3:0]             wstrb,
    // AXI4-Lite write response
    output logic                        bvalid,
    input  wire logic                   bready,
    output logic      [1:0]             bresp,
    // AXI4-Lite read
    input  wire logic                   arvalid,
    output logic                        arready,
    input  wire logic [POPC_ADDR_W-1:0] araddr,
    output logic                        rvalid,
    input  wire logic                   rready,
    output logic      [POPC_DATA_W-1:0] rdata,
    output logic      [1:0]             rresp,
    // Port output latches
    output logic      [7:0]             port_d_out,
    output logic      [7:0]             port_e_out,
    output logic      [7:0]             port_f_out,
    output logic      [4:0]             port_g_out,
    // Pin directions from the direction logic, 1 = output
    input  wire logic [5:0]             port_3_dir,
    input  wire logic [7:0]             port_a_dir,
    input  wire logic [7:0]             port_b_dir,
    input  wire logic [7:0]             port_c_dir,
    input  wire logic [7:0]             port_d_dir,
    input  wire logic [7:0]             port_e_dir,
    // Output data of ports 3 and A from their own latches
    input  wire logic [5:0]             port_3_data,
    input  wire logic [7:0]             port_a_data,
    // Pad drive enables for open-drain capable ports
    output logic      [5:0]             port_3_oe,
    output logic      [7:0]             port_a_oe,
    // Pad pull-up enables
    output logic      [7:0]             port_a_pull,
    output logic      [7:0]             port_b_pull,
    output logic      [7:0]             port_c_pull,
    output logic      [7:0]             port_d_pull,
    output logic      [7:0]             port_e_pull
);

    // Write channel states
    typedef enum logic [4:0] {
        W_IDLE = 5'h01,
        W_ADDR = 5'h02,
        W_DATA = 5'h04,
        W_EXEC = 5'h08,
        W_RESP = 5'h10
    } popc_wst_t;

    typedef struct packed {
        popc_wst_t        wst;
        logic [POPC_ADDR_W-1:0] waddr;
        logic [7:0]       wbyte;
        logic             wstb;
        logic [1:0]       bresp;
        logic             rvalid;
        logic [7:0]       rdata;
        logic [1:0]       rresp;
    } popc_state_t;

    popc_state_t q;
    popc_state_t d;

    logic [POPC_NSLOT-1:0]      we_vec;
    logic [POPC_NSLOT-1:0][7:0] reg_q;
    logic [4:0]                 wslot;
    logic [4:0]                 rslot;

    // Slot of a byte address, 5'h1F when outside the array
    function automatic logic [4:0] slot_of(input logic [POPC_ADDR_W-1:0] a);
        logic [15:0] off;
        off = a[POPC_ADDR_W-1:2] - POPC_IDX_BASE;
        slot_of = (off < 16'(POPC_NSLOT)) ? off[4:0] : 5'h1F;
    endfunction : slot_of

    // R8: ROM-only gating
    function automatic logic mapped(input logic [4:0] s);
        if (s == 5'h1F)
            mapped = 1'b0;
        else
            mapped = POPC_SLOT_PRESENT[s[3:0]]
                     && (ONCHIP_ROM || !POPC_SLOT_ROM_ONLY[s[3:0]]);
    endfunction : mapped

    assign wslot = slot_of(q.waddr);
    assign rslot = slot_of(araddr);

    // Bus handshakes; address and data are taken in either order
    assign awready = (q.wst == W_IDLE) || (q.wst == W_DATA);
    assign wready  = (q.wst == W_IDLE) || (q.wst == W_ADDR);
    assign bvalid  = (q.wst == W_RESP);
    assign bresp   = q.bresp;
    assign arready = !q.rvalid;
    assign rvalid  = q.rvalid;
    assign rdata   = {24'h000000, q.rdata};
    assign rresp   = q.rresp;

    // Next state of the bus slave
    always_comb
    begin
        d      = q;
        we_vec = '0;
        unique case (q.wst)
            W_IDLE:
            begin
                if (awvalid)
                    d.waddr = awaddr;
                if (wvalid)
                begin
                    d.wbyte = wdata[7:0];
                    d.wstb  = wstrb[0];
                end
                if (awvalid && wvalid)
                    d.wst = W_EXEC;
                else if (awvalid)
                    d.wst = W_ADDR;
                else if (wvalid)
                    d.wst = W_DATA;
            end
            W_ADDR:
            begin
                if (wvalid)
                begin
                    d.wbyte = wdata[7:0];
                    d.wstb  = wstrb[0];
                    d.wst   = W_EXEC;
                end
            end
            W_DATA:
            begin
                if (awvalid)
                begin
                    d.waddr = awaddr;
                    d.wst   = W_EXEC;
                end
            end
            W_EXEC:
            begin
                // Byte lane 0 only; other lanes carry no register bits
                if (mapped(wslot))
                    we_vec[wslot[3:0]] = q.wstb;
                d.bresp = mapped(wslot) ? POPC_RESP_OKAY : POPC_RESP_DECERR;
                d.wst   = W_RESP;
            end
            W_RESP:
                if (bready)
                    d.wst = W_IDLE;
        endcase

        // Read: one outstanding, answered the cycle after it is taken
        if (!q.rvalid && arvalid)
        begin
            d.rvalid = 1'b1;
            d.rdata  = mapped(rslot) ? reg_q[rslot[3:0]] : 8'h00;
            d.rresp  = mapped(rslot) ? POPC_RESP_OKAY : POPC_RESP_DECERR;
        end
        else if (q.rvalid && rready)
            d.rvalid = 1'b0;
    end

    // R9: slave reset
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            q <= '{wst: W_IDLE, bresp: POPC_RESP_OKAY,
                   rresp: POPC_RESP_OKAY, default: '0};
        else
            q <= d;
    end

    // Register slots; holes and absent slots never get a write strobe
    for (genvar i = 0; i < POPC_NSLOT; i++)
    begin : g_slot
        popc_reg #(
            .MASK (POPC_WMASK[i])
        ) u_reg (
            .aclk    (aclk),
            .aresetn (aresetn),
            .wr_en   (we_vec[i]),
            .wr_byte (q.wbyte),
            .rd_byte (reg_q[i])
        );
    end

    // R1: port D latch
    assign port_d_out = reg_q[POPC_SLOT_D_OUT];
    // R2: port E latch
    assign port_e_out = reg_q[POPC_SLOT_E_OUT];
    // R3: port F latch
    assign port_f_out = reg_q[POPC_SLOT_F_OUT];
    // R4: port G latch
    assign port_g_out = reg_q[POPC_SLOT_G_OUT][4:0];

    // R6: port 3 open-drain
    popc_pad #(
        .W (6)
    ) u_pad_3 (
        .aclk    (aclk),
        .aresetn (aresetn),
        .dir     (port_3_dir),
        .data    (port_3_data),
        .od      (reg_q[POPC_SLOT_3_OD][5:0]),
        .pue     (6'h00),
        .oe      (port_3_oe),
        .pull    ()
    );

    // R7: port A open-drain and pull-up
    popc_pad #(
        .W (8)
    ) u_pad_a (
        .aclk    (aclk),
        .aresetn (aresetn),
        .dir     (port_a_dir),
        .data    (port_a_data),
        .od      (reg_q[POPC_SLOT_A_OD]),
        .pue     (reg_q[POPC_SLOT_A_PU]),
        .oe      (port_a_oe),
        .pull    (port_a_pull)
    );

    // R5: port B pull-ups
    popc_pad #(
        .W (8)
    ) u_pad_b (
        .aclk    (aclk),
        .aresetn (aresetn),
        .dir     (port_b_dir),
        .data    (8'h00),
        .od      (8'h00),
        .pue     (reg_q[POPC_SLOT_B_PU]),
        .oe      (),
        .pull    (port_b_pull)
    );

    // R5: port C pull-ups
    popc_pad #(
        .W (8)
    ) u_pad_c (
        .aclk    (aclk),
        .aresetn (aresetn),
        .dir     (port_c_dir),
        .data    (8'h00),
        .od      (8'h00),
        .pue     (reg_q[POPC_SLOT_C_PU]),
        .oe      (),
        .pull    (port_c_pull)
    );

    // R5: port D pull-ups
    popc_pad #(
        .W (8)
    ) u_pad_d (
        .aclk    (aclk),
        .aresetn (aresetn),
        .dir     (port_d_dir),
        .data    (8'h00),
        .od      (8'h00),
        .pue     (reg_q[POPC_SLOT_D_PU]),
        .oe      (),
        .pull    (port_d_pull)
    );

    // R5: port E pull-ups
    popc_pad #(
        .W (8)
    ) u_pad_e (
        .aclk    (aclk),
        .aresetn (aresetn),
        .dir     (port_e_dir),
        .data    (8'h00),
        .od      (8'h00),
        .pue     (reg_q[POPC_SLOT_E_PU]),
        .oe      (),
        .pull    (port_e_pull)
    );

    // Checks, all on the one clock
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    sequence s_wr_take;
        awvalid && awready && wvalid && wready;
    endsequence

    sequence s_wr_answer;
        !bvalid ##1 bvalid;
    endsequence

    a_write_resp: assert property (s_wr_take |=> s_wr_answer)
        else $error("write response not two cycles after accept");

    a_read_lat: assert property (arvalid && arready
        |=> rvalid && rdata[31:8] == 24'h000000)
        else $error("read answer late or upper bits set");

    a_pd_latch: assert property ( // R1
        we_vec[POPC_SLOT_D_OUT] |=> port_d_out == $past(q.wbyte))
        else $error("port D latch missed write");
    a_pe_latch: assert property ( // R2
        we_vec[POPC_SLOT_E_OUT] |=> port_e_out == $past(q.wbyte))
        else $error("port E latch missed write");
    a_pf_latch: assert property ( // R3
        we_vec[POPC_SLOT_F_OUT] |=> port_f_out == $past(q.wbyte))
        else $error("port F latch missed write");
    a_pg_latch: assert property ( // R4
        we_vec[POPC_SLOT_G_OUT] |=> port_g_out == $past(q.wbyte[4:0])
        && reg_q[POPC_SLOT_G_OUT][7:5] == 3'h0)
        else $error("port G latch wrong");

    a_pu_reach: assert property ( // R5
        we_vec[POPC_SLOT_E_PU] |=> ##1
        port_e_pull == ($past(q.wbyte, 2) & ~$past(port_e_dir)))
        else $error("port E pull-up not applied");

    a_p3_od_bits: assert property ( // R6
        we_vec[POPC_SLOT_3_OD] |=> reg_q[POPC_SLOT_3_OD]
        == ($past(q.wbyte) & POPC_WMASK[POPC_SLOT_3_OD]))
        else $error("port 3 open-drain bits wrong");
    a_pa_od_pin: assert property ( // R7
        1'b1 |=> port_a_oe == $past(port_a_dir
        & ~(reg_q[POPC_SLOT_A_OD] & port_a_data)))
        else $error("port A drive enable wrong");
    a_rom_gate: assert property ( // R8
        !ONCHIP_ROM |-> (reg_q[POPC_SLOT_A_PU] | reg_q[POPC_SLOT_E_PU]
        | reg_q[POPC_SLOT_A_OD]) == 8'h00)
        else $error("ROM-only register written without ROM");

    a_reset_zero: assert property ( // R9
        $rose(aresetn) |-> port_d_out == 8'h00 && port_g_out == 5'h00
        && port_a_pull == 8'h00 && port_3_oe == 6'h00 && !bvalid)
        else $error("state not cleared by reset");
    a_pull_input: assert property ( // R10
        ##1 ((port_a_pull & $past(port_a_dir))
        | (port_c_pull & $past(port_c_dir))
        | (port_e_pull & $past(port_e_dir))) == 8'h00)
        else $error("pull-up on an output pin");

endmodule : popc_top

// ### testbench/popc_board.sv
// Board-side model of the port A pins
`timescale 1ns/1ps
module popc_board
(
    // Clock
    input  wire logic       aclk,
    // Pad controls and data from the device
    input  wire logic [7:0] oe,
    input  wire logic [7:0] data,
    input  wire logic [7:0] pull,
    // Level seen on the pins
    output logic      [7:0] pin
);
    // A floating pin toggles, so a stale level never looks settled
    always @(posedge aclk)
    begin
        for (int i = 0; i < 8; i++)
        begin
            if (oe[i])
                pin[i] <= data[i];
            else if (pull[i])
                pin[i] <= 1'b1;
            else
                pin[i] <= (pin[i] === 1'b1) ? 1'b0 : 1'b1;
        end
    end
endmodule : popc_board

// ### testbench/tb.sv
// Self-checking bench for the port output and pad control block
`timescale 1ns/1ps
module tb
    import popc_pkg::*;
;
    // Bus and clock
    logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready;
    logic [POPC_ADDR_W-1:0] awaddr, araddr;
    logic [POPC_DATA_W-1:0] wdata, rdata, rd;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp, resp;
    // Port pins
    logic [7:0] port_d_out, port_e_out, port_f_out, port_a_oe, pin_a;
    logic [4:0] port_g_out;
    logic [5:0] port_3_dir, port_3_data, port_3_oe;
    logic [7:0] port_a_dir, port_b_dir, port_c_dir, port_d_dir;
    logic [7:0] port_e_dir, port_a_data, port_a_pull, port_b_pull;
    logic [7:0] port_c_pull, port_d_pull, port_e_pull;
    int mismatches, tests_run, cycles;
    // Outputs of the variant without on-chip program memory
    logic [7:0] nr_d_out, nr_oe_a, nr_pull_a, nr_pull_e;
    logic [31:0] nr_rdata, nr_rd;
    logic [1:0] nr_bresp, nr_rresp, nr_resp;
    logic ro;

    typedef struct packed {
        logic [15:0] idx;
        logic [7:0]  wd;
        logic [7:0]  rd;
        logic [1:0]  rsp;
    } popc_row_t;
    localparam logic [1:0] OK = POPC_RESP_OKAY;
    localparam logic [1:0] DE = POPC_RESP_DECERR;
    // Index, written byte, byte read back, response
    localparam popc_row_t ROWS [14] = '{
        '{16'hFF6C, 8'h5A, 8'h5A, OK}, '{16'hFF6D, 8'hA5, 8'hA5, OK},
        '{16'hFF6E, 8'h3C, 8'h3C, OK}, '{16'hFF6F, 8'hFF, 8'h1F, OK},
        '{16'hFF70, 8'hFF, 8'hFF, OK}, '{16'hFF71, 8'hAA, 8'hAA, OK},
        '{16'hFF72, 8'h55, 8'h55, OK}, '{16'hFF73, 8'h0F, 8'h0F, OK},
        '{16'hFF74, 8'hF0, 8'hF0, OK}, '{16'hFF75, 8'hFF, 8'h00, DE},
        '{16'hFF76, 8'hFF, 8'h3F, OK}, '{16'hFF77, 8'hFF, 8'hFF, OK},
        '{16'hFF78, 8'h77, 8'h00, DE}, '{16'hFF6B, 8'h12, 8'h00, DE}};

    popc_top #(.ONCHIP_ROM(1'b1)) u_dut (.aclk, .aresetn, .awvalid,
        .awready, .awaddr, .wvalid, .wready, .wdata, .wstrb, .bvalid,
        .bready, .bresp, .arvalid, .arready, .araddr, .rvalid, .rready,
        .rdata, .rresp, .port_d_out, .port_e_out, .port_f_out,
        .port_g_out, .port_3_dir, .port_a_dir, .port_b_dir, .port_c_dir,
        .port_d_dir, .port_e_dir, .port_3_data, .port_a_data, .port_3_oe,
        .port_a_oe, .port_a_pull, .port_b_pull, .port_c_pull,
        .port_d_pull, .port_e_pull);

    popc_board u_board (.aclk, .oe(port_a_oe), .data(port_a_data),
        .pull(port_a_pull), .pin(pin_a));

    // Same bus and pins; ROM-only registers must be absent here
    popc_top #(.ONCHIP_ROM(1'b0)) u_dut_norom (.aclk, .aresetn, .awvalid,
        .awready(), .awaddr, .wvalid, .wready(), .wdata, .wstrb,
        .bvalid(), .bready, .bresp(nr_bresp), .arvalid, .arready(),
        .araddr, .rvalid(), .rready, .rdata(nr_rdata), .rresp(nr_rresp),
        .port_d_out(nr_d_out), .port_e_out(), .port_f_out(),
        .port_g_out(), .port_3_dir, .port_a_dir, .port_b_dir, .port_c_dir,
        .port_d_dir, .port_e_dir, .port_3_data, .port_a_data,
        .port_3_oe(), .port_a_oe(nr_oe_a), .port_a_pull(nr_pull_a),
        .port_b_pull(), .port_c_pull(), .port_d_pull(),
        .port_e_pull(nr_pull_e));

    // Clock, 4 ns period
    always #2 aclk = ~aclk;

    task automatic check(input string what, input logic [31:0] seen,
                         input logic [31:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic results;
        $display("comparisons %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : results

    // Ready sampled mid-cycle, where it already holds its edge value
    task automatic bus_write(input logic [15:0] idx, input logic [7:0] d,
                             input logic [3:0] st);
        logic aw_go, w_go, b_go;
        @(posedge aclk);
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        awaddr <= {idx, 2'b00};
        wdata <= {24'h0, d};
        wstrb <= st;
        do
        begin
            @(negedge aclk);
            aw_go = awvalid && awready;
            w_go = wvalid && wready;
            @(posedge aclk);
            if (aw_go)
                awvalid <= 1'b0;
            if (w_go)
                wvalid <= 1'b0;
        end
        while ((awvalid && !aw_go) || (wvalid && !w_go));
        do
        begin
            @(negedge aclk);
            b_go = bvalid;
            resp = bresp;
            nr_resp = nr_bresp;
            @(posedge aclk);
        end
        while (!b_go);
        bready <= 1'b0;
    endtask : bus_write

    task automatic bus_read(input logic [15:0] idx);
        logic go;
        @(posedge aclk);
        arvalid <= 1'b1;
        rready <= 1'b1;
        araddr <= {idx, 2'b00};
        do
        begin
            @(negedge aclk);
            go = arready;
            @(posedge aclk);
        end
        while (!go);
        arvalid <= 1'b0;
        do
        begin
            @(negedge aclk);
            go = rvalid;
            rd = rdata;
            resp = rresp;
            nr_rd = nr_rdata;
            nr_resp = nr_rresp;
            @(posedge aclk);
        end
        while (!go);
        rready <= 1'b0;
    endtask : bus_read

    // Pad outputs lag their inputs by a cycle, the board one more
    task automatic settle;
        repeat (2) @(posedge aclk);
        @(negedge aclk);
    endtask : settle

    // Hang guard, well above the expected run length
    always @(posedge aclk)
    begin
        cycles <= cycles + 1;
        if (cycles == 5000)
        begin
            mismatches++;
            results;
        end
    end

    initial
    begin
        aclk = 0; aresetn = 0; awvalid = 0; wvalid = 0; bready = 0;
        arvalid = 0; rready = 0; awaddr = '0; araddr = '0; wdata = '0;
        wstrb = '0; port_3_dir = '0; port_3_data = '0; port_a_dir = '0;
        port_b_dir = '0; port_c_dir = '0; port_d_dir = '0; port_e_dir = '0;
        port_a_data = '0; mismatches = 0; tests_run = 0; cycles = 0;
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        @(negedge aclk);
        check("latches", {port_d_out, port_e_out, port_f_out,
              port_g_out}, 0);
        check("pulls", {port_a_pull, port_b_pull, port_c_pull}, 0);
        $display("test reset done");
        foreach (ROWS[i])
        begin
            ro = ROWS[i].idx inside {[POPC_IDX_PORT_A_PU:POPC_IDX_PORT_E_PU],
                                     POPC_IDX_PORT_A_OD};
            bus_write(ROWS[i].idx, ROWS[i].wd, 4'hF);
            check($sformatf("bresp %h", ROWS[i].idx), resp, ROWS[i].rsp);
            check($sformatf("no rom bresp %h", ROWS[i].idx), nr_resp,
                  ro ? DE : ROWS[i].rsp);
            bus_read(ROWS[i].idx);
            check($sformatf("rdata %h", ROWS[i].idx), rd, ROWS[i].rd);
            check($sformatf("rresp %h", ROWS[i].idx), resp, ROWS[i].rsp);
            check($sformatf("no rom rdata %h", ROWS[i].idx), nr_rd,
                  ro ? 8'h00 : ROWS[i].rd);
            check($sformatf("no rom rresp %h", ROWS[i].idx), nr_resp,
                  ro ? DE : ROWS[i].rsp);
        end
        @(negedge aclk);
        check("latches", {port_d_out, port_e_out, port_f_out, port_g_out},
              {8'h5A, 8'hA5, 8'h3C, 5'h1F});
        check("pulls in", {port_a_pull, port_b_pull, port_c_pull,
              port_d_pull}, 32'hFFAA550F);
        check("pull e in", port_e_pull, 8'hF0);
        check("no rom pulls", {nr_pull_a, nr_pull_e}, 0);
        check("no rom latch", nr_d_out, 8'h5A);
        $display("test table done");
        @(posedge aclk);
        port_a_dir <= 8'h0F;
        port_a_data <= 8'h05;
        port_3_dir <= 6'h3F;
        port_3_data <= 6'h2A;
        port_b_dir <= 8'hFF;
        port_c_dir <= 8'hFF;
        port_d_dir <= 8'hFF;
        port_e_dir <= 8'hFF;
        settle;
        check("port a oe", port_a_oe, 8'h0A);
        check("no rom oe", nr_oe_a, 8'h0F);
        check("port 3 oe", port_3_oe, 6'h15);
        check("port a pull", port_a_pull, 8'hF0);
        check("pulls out", {port_b_pull, port_c_pull, port_d_pull,
              port_e_pull}, 0);
        check("pin a", pin_a & 8'hFA, 8'hF0);
        bus_write(POPC_IDX_PORT_A_OD, 8'h00, 4'hF);
        settle;
        check("port a push", port_a_oe, 8'h0F);
        $display("test pads done");
        bus_write(POPC_IDX_PORT_D_OUT, 8'hC3, 4'h0);
        check("strobe resp", resp, OK);
        check("strobe off", port_d_out, 8'h5A);
        $display("test strobe done");
        @(posedge aclk);
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        settle;
        check("latches rst", {port_d_out, port_e_out, port_f_out,
              port_g_out}, 0);
        check("port a pull rst", port_a_pull, 0);
        check("port 3 oe rst", port_3_oe, 6'h3F);
        bus_read(POPC_IDX_PORT_E_PU);
        check("pull e rst", rd, 0);
        $display("test mid reset done");
        results;
    end
endmodule : tb
